// ### hdl/tws_pkg.sv
// Notes on behaviour
// R1: Low three address bits come from the three address-select pins.
// R2: Open address-select pins read as zero through pad pull-downs.
// R3: Master starts and clocks every transfer; this slave never starts one.
// R4: Sample data on clock rise; change driven data only after clock fall.
// R5: Clock and data inputs pass spike-suppression filtering.
// R6: Bytes travel most significant bit first, one bit per clock.
// R7: Each byte is eight data clocks plus one acknowledge clock.
// R8: Master supplies byte and acknowledge clocks back to back.
// R9: Data changes only while clock low; change while high is start/stop.
// R10: Any number of data bytes accepted between start and stop.
// R11: Bus idle only while clock and data are both high.
// R12: Start is data falling while clock high; precedes every command.
// R13: Watch for start always; ignore bus activity until one is seen.
// R14: Stop is data rising while clock high; ends transfer, back to idle.
// R15: Repeated start begins a new operation.
// R16: Acknowledge by driving data low for the whole ninth clock.
// R17: Master no-acknowledge on a read makes the slave release data.
// R18: Invalid operations are answered with a no-acknowledge.
// R19: Upper four address bits select sensor or memory function.
// R20: Last address bit: one means master reads, zero means master writes.
// R21: Acknowledge a matching address; otherwise no-acknowledge and idle.
// R22: Clock and data are synchronised by two flip-flops before detection.
// R23: Data output only drives low or releases, never drives high.
package tws_pkg;
   localparam int           CLK_PERIOD_NS = 8;
   localparam int           SPIKE_NS      = 16;
   localparam int           FILT_CALC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           FILT_CYC      = (FILT_CALC < 1) ? 1 : FILT_CALC;
   localparam int           FILT_W        = 4;
   localparam int           BYTE_BITS     = 8;
   localparam logic [3:0]   BIT_LAST      = 4'h8;
   localparam logic [3:0]   TYPE_SENSOR   = 4'h9;
   localparam logic [3:0]   TYPE_MEMORY   = 4'ha;
   localparam int           ADDR_TYPE_HI  = 7;
   localparam int           ADDR_TYPE_LO  = 4;
   localparam int           ADDR_SEL_HI   = 3;
   localparam int           ADDR_SEL_LO   = 1;
   localparam int           ADDR_DIR_BIT  = 0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR,
      ST_WR_ACK,
      ST_RD,
      ST_RD_ACK
   } tws_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } tws_lines_t;

   typedef struct packed {
      logic       scl_rise;
      logic       scl_fall;
      logic       start;
      logic       stop;
      logic       idle;
   } tws_events_t;

   typedef struct packed {
      logic [7:0] data;
      logic       func_mem;
   } tws_rx_t;
endpackage

// ### hdl/tws_in_filter.sv
`timescale 1ns/10ps
`default_nettype none
module tws_in_filter
   import tws_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire tws_lines_t lines_in,
   output tws_lines_t      lines_out
);
   logic [1:0] raw;
   logic [1:0] filt;

   assign raw = {lines_in.scl, lines_in.sda};
   assign lines_out = '{scl: filt[1], sda: filt[0]};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         logic              meta_r;
         logic              sync_r;
         logic              out_r;
         logic [FILT_W-1:0] cnt_r;
         logic [FILT_W-1:0] cnt_nxt;

         assign cnt_nxt = (sync_r == out_r) ? '0 : cnt_r + 1'b1;
         assign filt[g] = out_r;

         // Two-stage synchroniser
         always_ff @(posedge sys_clk_in) begin // R22
            if (srst_in) begin
               meta_r <= 1'b1;
               sync_r <= 1'b1;
            end else begin
               meta_r <= raw[g];
               sync_r <= meta_r;
            end
         end

         // Output follows only after a stable run
         always_ff @(posedge sys_clk_in) begin // R5
            if (srst_in) begin
               out_r <= 1'b1;
               cnt_r <= '0;
            end else if (cnt_nxt == FILT_W'(FILT_CYC)) begin
               out_r <= sync_r;
               cnt_r <= '0;
            end else begin
               cnt_r <= cnt_nxt;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### hdl/tws_cond_det.sv
`timescale 1ns/10ps
`default_nettype none
module tws_cond_det
   import tws_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire tws_lines_t lines_in,
   output tws_events_t     events_out
);
   tws_lines_t prev_r;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         prev_r <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         prev_r <= lines_in;
      end
   end

   assign events_out.scl_rise = lines_in.scl & ~prev_r.scl;
   assign events_out.scl_fall = ~lines_in.scl & prev_r.scl;
   // Data edge while clock stays high
   assign events_out.start = lines_in.scl & prev_r.scl & prev_r.sda & ~lines_in.sda; // R12 R9
   assign events_out.stop  = lines_in.scl & prev_r.scl & ~prev_r.sda & lines_in.sda; // R14 R9
   assign events_out.idle  = lines_in.scl & lines_in.sda; // R11
endmodule
`default_nettype wire

// ### hdl/tws_slave.sv
`timescale 1ns/10ps
`default_nettype none
module tws_slave
   import tws_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic [2:0] address_select_pins_in,
   output tws_rx_t         rx_byte_out,
   output logic            rx_valid_out,
   output logic            rd_start_out,
   output logic            tx_next_out,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       refuse_in,
   output logic            busy_out,
   output logic            bus_idle_out
);
   tws_lines_t  pin_lines;
   tws_lines_t  filt;
   tws_events_t ev;
   tws_state_t  state_r;
   tws_state_t  state_nxt;
   logic [3:0]  bit_cnt_r;
   logic [7:0]  shift_r;
   logic        oe_r;
   logic        func_mem_r;
   logic [2:0]  pins_meta_r;
   logic [2:0]  pins_r;
   tws_rx_t     rx_r;
   logic        rx_valid_r;
   logic        rd_start_r;
   logic        tx_next_r;
   logic        busy_r;
   logic        idle_r;

   assign pin_lines = '{scl: scl_in, sda: sda_in};
   tws_in_filter u_filter (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .lines_in   (pin_lines),
      .lines_out  (filt)
   );

   tws_cond_det u_det (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .lines_in   (filt),
      .events_out (ev)
   );

   // Address pins, pad pull-downs make open pins read zero
   always_ff @(posedge sys_clk_in) begin // R2
      if (srst_in) begin
         pins_meta_r <= 3'h0;
         pins_r      <= 3'h0;
      end else begin
         pins_meta_r <= address_select_pins_in;
         pins_r      <= pins_meta_r;
      end
   end

   // Device-type field test
   function automatic logic type_is(input logic [7:0] ab, input logic [3:0] typ);
      return ab[ADDR_TYPE_HI:ADDR_TYPE_LO] == typ;
   endfunction

   // Address decode
   wire [7:0] addr_byte = shift_r;
   wire       type_sens = type_is(addr_byte, TYPE_SENSOR); // R19
   wire       type_mem  = type_is(addr_byte, TYPE_MEMORY); // R19
   wire       sel_match = addr_byte[ADDR_SEL_HI:ADDR_SEL_LO] == pins_r; // R1
   wire       addr_hit  = (type_sens | type_mem) & sel_match; // R21
   wire       dir_read  = addr_byte[ADDR_DIR_BIT]; // R20
   wire       byte_full = bit_cnt_r == BIT_LAST; // R7
   wire       rx_state  = (state_r == ST_ADDR) || (state_r == ST_WR);
   wire       fall_full = ev.scl_fall & byte_full;
   wire       load_tx   = ev.scl_fall & ((state_r == ST_ADDR_ACK & dir_read) |
                          (state_r == ST_RD_ACK));

   // Next state
   always_comb begin
      state_nxt = state_r;
      if (ev.start) begin
         state_nxt = ST_ADDR; // R13 R15
      end else if (ev.stop) begin
         state_nxt = ST_IDLE; // R14
      end else begin
         case (state_r)
            ST_IDLE: state_nxt = ST_IDLE; // R3
            ST_ADDR: begin
               if (fall_full) begin
                  state_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE; // R21
               end
            end
            ST_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  state_nxt = dir_read ? ST_RD : ST_WR; // R20
               end
            end
            ST_WR: begin
               if (fall_full) begin
                  state_nxt = ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               if (ev.scl_fall) begin
                  state_nxt = ST_WR; // R10
               end
            end
            ST_RD: begin
               if (fall_full) begin
                  state_nxt = ST_RD_ACK;
               end
            end
            ST_RD_ACK: begin
               if (ev.scl_rise && filt.sda) begin
                  state_nxt = ST_IDLE; // R17
               end else if (ev.scl_fall) begin
                  state_nxt = ST_RD;
               end
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bit counter and shifter
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
      end else if (ev.start) begin
         bit_cnt_r <= 4'h0;
      end else if (load_tx) begin
         bit_cnt_r <= 4'h0;
         shift_r   <= tx_data_in;
      end else if (ev.scl_rise && (rx_state || state_r == ST_RD)) begin
         bit_cnt_r <= bit_cnt_r + 4'h1; // R7 R8
         if (rx_state) begin
            shift_r <= {shift_r[6:0], filt.sda}; // R4 R6
         end
      end else if (ev.scl_fall && state_r == ST_RD && !byte_full) begin
         shift_r <= {shift_r[6:0], 1'b0}; // R6
      end else if (ev.scl_fall && (state_r == ST_WR_ACK || state_r == ST_ADDR_ACK)) begin
         bit_cnt_r <= 4'h0;
      end
   end

   // Open-drain data drive, updated on clock fall; also released on start, stop or a clock rise in ST_RD_ACK
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         oe_r <= 1'b0;
      end else if (ev.start || ev.stop) begin
         oe_r <= 1'b0;
      end else if (ev.scl_fall) begin // R4
         case (state_r)
            ST_ADDR:     oe_r <= byte_full & addr_hit; // R21
            ST_WR:       oe_r <= byte_full & ~refuse_in; // R16 R18
            ST_ADDR_ACK: oe_r <= dir_read & ~tx_data_in[7]; // R6
            ST_RD_ACK:   oe_r <= ~tx_data_in[7];
            ST_RD:       oe_r <= ~byte_full & ~shift_r[6];
            default:     oe_r <= 1'b0;
         endcase
      end else if (ev.scl_rise && state_r == ST_RD_ACK) begin
         oe_r <= 1'b0; // R17
      end
   end

   // User-side strobes
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rx_r       <= '0;
         rx_valid_r <= 1'b0;
         rd_start_r <= 1'b0;
         tx_next_r  <= 1'b0;
         func_mem_r <= 1'b0;
         busy_r     <= 1'b0;
         idle_r     <= 1'b1;
      end else begin
         rx_valid_r <= 1'b0;
         rd_start_r <= 1'b0;
         tx_next_r  <= 1'b0;
         busy_r     <= state_nxt != ST_IDLE;
         idle_r     <= ev.idle; // R11
         if (ev.scl_fall && state_r == ST_ADDR && byte_full && addr_hit) begin
            func_mem_r <= type_mem;
            rd_start_r <= dir_read;
         end
         if (fall_full && state_r == ST_WR) begin
            rx_r       <= '{data: shift_r, func_mem: func_mem_r};
            rx_valid_r <= 1'b1; // R10
         end
         if (ev.scl_rise && state_r == ST_RD_ACK && !filt.sda) begin
            tx_next_r <= 1'b1;
         end
      end
   end

   assign sda_out      = 1'b0; // R23
   assign sda_oe_out   = oe_r;
   assign rx_byte_out  = rx_r;
   assign rx_valid_out = rx_valid_r;
   assign rd_start_out = rd_start_r;
   assign tx_next_out  = tx_next_r;
   assign busy_out     = busy_r;
   assign bus_idle_out = idle_r;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_addr_hit;
      state_r == ST_ADDR && ev.scl_fall && byte_full && addr_hit && !ev.start && !ev.stop;
   endsequence
   sequence s_addr_miss;
      state_r == ST_ADDR && ev.scl_fall && byte_full && !addr_hit && !ev.start && !ev.stop;
   endsequence
   sequence s_wr_end;
      state_r == ST_WR && ev.scl_fall && byte_full && !ev.start && !ev.stop;
   endsequence
   sequence s_rd_end;
      state_r == ST_RD && ev.scl_fall && byte_full && !ev.start && !ev.stop;
   endsequence
   sequence s_ack_fall;
      state_r == ST_ADDR_ACK && ev.scl_fall && !ev.start && !ev.stop;
   endsequence
   sequence s_mack_rise;
      state_r == ST_RD_ACK && ev.scl_rise && !filt.sda && !ev.stop;
   endsequence

   AST_NEVER_HIGH: assert property (sda_out == 1'b0) // R23
      else $error("data pin driven high");
   AST_IDLE_QUIET: assert property (state_r == ST_IDLE |=> !oe_r || $past(ev.scl_fall)) // R13
      else $error("data driven while idle");
   AST_STOP_IDLE: assert property (ev.stop |=> state_r == ST_IDLE && !oe_r) // R14
      else $error("stop did not return to idle");
   AST_START_ADDR: assert property (ev.start |=> state_r == ST_ADDR && bit_cnt_r == 4'h0) // R15
      else $error("start did not open address phase");
   AST_ADDR_ACK: assert property (s_addr_hit |=> state_r == ST_ADDR_ACK && oe_r) // R21
      else $error("matching address not acknowledged");
   AST_ADDR_NACK: assert property (s_addr_miss |=> state_r == ST_IDLE && !oe_r) // R21
      else $error("foreign address acknowledged");
   AST_WR_REFUSE: assert property (s_wr_end ##0 refuse_in |=> !oe_r && state_r == ST_WR_ACK) // R18
      else $error("refused byte acknowledged");
   AST_ACK_HOLD: assert property (state_r == ST_WR_ACK && oe_r && !ev.scl_fall // R16
                                  && !ev.start && !ev.stop |=> oe_r)
      else $error("acknowledge released early");
   AST_RD_RELEASE: assert property (state_r == ST_RD_ACK && ev.scl_rise && filt.sda // R17
                                    && !ev.stop |=> state_r == ST_IDLE && !oe_r)
      else $error("no release after master nack");
   AST_OE_ON_FALL: assert property ($rose(oe_r) |-> $past(ev.scl_fall)) // R4
      else $error("data drive changed off a clock fall");
   AST_MSB_OUT: assert property (load_tx && !ev.start && !ev.stop // R6
                                 |=> oe_r == ~$past(tx_data_in[7]))
      else $error("read byte not sent msb first");
   AST_RX_BYTE: assert property (s_wr_end |=> rx_valid_out && rx_byte_out.data == $past(shift_r)) // R10
      else $error("received byte not delivered");
   AST_WR_ACK: assert property (s_wr_end ##0 !refuse_in |=> oe_r && state_r == ST_WR_ACK) // R16
      else $error("accepted byte not acknowledged");
   AST_ACK_END: assert property (state_r == ST_WR_ACK && ev.scl_fall && !ev.start // R10
                                 && !ev.stop |=> !oe_r && state_r == ST_WR)
      else $error("acknowledge not released for next byte");
   AST_RD_FREE: assert property (s_rd_end |=> !oe_r && state_r == ST_RD_ACK) // R7
      else $error("data not released for master answer");
   AST_RD_START: assert property (s_addr_hit ##0 dir_read |=> rd_start_out) // R20
      else $error("read address gave no first byte request");
   AST_WR_OPEN: assert property (s_ack_fall ##0 !dir_read // R20
                                 |=> state_r == ST_WR && bit_cnt_r == 4'h0 && !oe_r)
      else $error("write phase not opened cleanly");
   AST_RD_OPEN: assert property (s_ack_fall ##0 dir_read // R20
                                 |=> state_r == ST_RD && bit_cnt_r == 4'h0)
      else $error("read phase not opened cleanly");
   AST_TX_NEXT: assert property (s_mack_rise |=> tx_next_out && state_r == ST_RD_ACK) // R10
      else $error("master ack gave no next byte request");
   AST_RD_SHIFT: assert property (state_r == ST_RD && ev.scl_fall && !byte_full // R6
                                  && !ev.start && !ev.stop |=> oe_r == ~$past(shift_r[6]))
      else $error("read bit out of order");
   AST_BIT_RANGE: assert property (bit_cnt_r <= BIT_LAST) // R7
      else $error("bit count ran past one byte");
   AST_IGNORE: assert property (state_r == ST_IDLE && !ev.start // R13
                                |=> state_r == ST_IDLE && !oe_r)
      else $error("bus activity taken without start");
   AST_RX_SHIFT: assert property (rx_state && !ev.scl_rise |=> $stable(shift_r)) // R4
      else $error("received data shifted off a clock rise");
   AST_OE_HOLD: assert property (!ev.scl_fall && !ev.start && !ev.stop // R9
                                 && !(ev.scl_rise && state_r == ST_RD_ACK) |=> $stable(oe_r))
      else $error("data drive changed while clock high");
   AST_RX_PULSE: assert property (rx_valid_out |=> !rx_valid_out) // R7
      else $error("received byte strobe longer than one cycle");
   AST_STOP_BUSY: assert property (ev.stop |=> !busy_out) // R14
      else $error("busy left high after stop");
   AST_START_FREE: assert property (ev.start |=> !oe_r && !rx_valid_out) // R15
      else $error("start did not release data");
endmodule
`default_nettype wire

// ### dv/tws_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module tws_master_model
   import tws_pkg::*;
#(
   parameter int LOW_CYC  = 6,
   parameter int HIGH_CYC = 4
) (
   input  wire logic sys_clk_in,
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_low_out
);
   // Clock stands high and data released between frames
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // Data moves two cycles after clock fall; optional one-cycle clock spike
   task automatic put_bit(input logic b, input logic gl, output logic s);
      cyc(2);
      sda_low_out = ~b;
      cyc(1);
      scl_out = gl;
      cyc(1);
      scl_out = 1'b0;
      cyc(LOW_CYC - 4);
      scl_out = 1'b1;
      cyc(HIGH_CYC);
      s = sda_in;
      scl_out = 1'b0;
   endtask

   // Start from idle, or repeated start after a byte
   task automatic start_cond();
      cyc(2);
      sda_low_out = 1'b0;
      cyc(LOW_CYC - 2);
      scl_out = 1'b1;
      cyc(HIGH_CYC);
      sda_low_out = 1'b1;
      cyc(HIGH_CYC);
      scl_out = 1'b0;
   endtask

   task automatic stop_cond();
      cyc(2);
      sda_low_out = 1'b1;
      cyc(LOW_CYC - 2);
      scl_out = 1'b1;
      cyc(HIGH_CYC);
      sda_low_out = 1'b0;
      cyc(HIGH_CYC);
   endtask

   // Nine clocks back to back; ack slot carries mack
   task automatic xfer(input logic [7:0] wb, input logic mack, input logic gl,
                       output logic [7:0] rb, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(wb[i], gl && (i == 7), rb[i]);
      end
      put_bit(mack, 1'b0, ack);
   endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import tws_pkg::*;
;
   logic        sys_clk_in = 1'b0;
   logic        srst_in    = 1'b1;
   logic [2:0]  pins       = 3'h0;
   logic [7:0]  tx_data    = 8'h5a;
   logic        refuse     = 1'b0;
   logic        scl, m_low, sda_out, sda_oe, rx_valid, rd_start, tx_next, busy, bus_idle;
   tws_rx_t     rx_byte;
   wire logic   sda_wire;
   int          checks     = 0;
   int          failures   = 0;
   logic [31:0] seed       = 32'h29;
   logic [8:0]  rxq[$];
   logic [7:0]  txq[$];

   // Open-drain wire with pull-up
   assign sda_wire = ~m_low & (sda_oe ? sda_out : 1'b1);

   tws_slave tws_slave_inst (
      .sys_clk_in             (sys_clk_in),
      .srst_in                (srst_in),
      .scl_in                 (scl),
      .sda_in                 (sda_wire),
      .sda_out                (sda_out),
      .sda_oe_out             (sda_oe),
      .address_select_pins_in (pins),
      .rx_byte_out            (rx_byte),
      .rx_valid_out           (rx_valid),
      .rd_start_out           (rd_start),
      .tx_next_out            (tx_next),
      .tx_data_in             (tx_data),
      .refuse_in              (refuse),
      .busy_out               (busy),
      .bus_idle_out           (bus_idle)
   );

   tws_master_model tws_master_model_inst (
      .sys_clk_in  (sys_clk_in),
      .sda_in      (sda_wire),
      .scl_out     (scl),
      .sda_low_out (m_low)
   );

   always #4 sys_clk_in = ~sys_clk_in;

   // Collect received bytes, feed bytes to send
   always @(negedge sys_clk_in) begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_byte);
      if ((rd_start === 1'b1 || tx_next === 1'b1) && txq.size() > 0)
         tx_data <= txq.pop_front();
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic exp_nack(input logic [3:0] typ, input logic [2:0] sel);
      return !(((typ == TYPE_SENSOR) || (typ == TYPE_MEMORY)) && (sel == pins));
   endfunction

   function automatic logic [8:0] exp_rx(input logic [7:0] d, input logic [3:0] typ);
      return {d, typ == TYPE_MEMORY};
   endfunction

   task automatic chk(input string what, input logic [8:0] want, input logic [8:0] got);
      checks++;
      if (got !== want) begin
         failures++;
         $display("Error %s expected %h seen %h", what, want, got);
      end
   endtask

   task automatic done(input string name);
      $display("Test %s finished, failures so far %0d", name, failures);
   endtask

   task automatic stop_test();
      $display("Checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (!(bus_idle === 1'b1 && busy === 1'b0) && n < 40) begin
         @(negedge sys_clk_in);
         n++;
      end
      checks++;
      if (n == 40) begin
         failures++;
         $display("Error idle_wait expected 1 seen 0");
         stop_test();
      end
   endtask

   task automatic write_frame(input logic [3:0] typ, input logic [2:0] sel, input int n,
                              input int ref_idx, input logic gl, input logic do_stop);
      logic       a;
      logic       nk;
      logic [7:0] d;
      logic [7:0] rb;
      nk = exp_nack(typ, sel);
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer({typ, sel, 1'b0}, 1'b1, 1'b0, rb, a);
      chk("addr_ack", {8'h0, nk}, {8'h0, a});
      chk("busy", {8'h0, ~nk}, {8'h0, busy});
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         refuse = (i == ref_idx);
         tws_master_model_inst.xfer(d, 1'b1, gl && (i == 0), rb, a);
         refuse = 1'b0;
         chk("data_ack", {8'h0, nk | (i == ref_idx)}, {8'h0, a});
         if (!nk && i != ref_idx)
            chk("rx_byte", exp_rx(d, typ), rxq.size() == 1 ? rxq[0] : 9'h1ff);
         else if (nk)
            chk("rx_count", 9'h0, 9'(rxq.size()));
         rxq.delete();
      end
      if (do_stop) begin
         tws_master_model_inst.stop_cond();
         wait_idle();
      end
   endtask

   task automatic read_frame(input logic [3:0] typ, input int n);
      logic       a;
      logic [7:0] rb;
      logic [7:0] want[$];
      for (int i = 0; i < n; i++)
         want.push_back(8'(rnd()));
      txq = want;
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer({typ, pins, 1'b1}, 1'b1, 1'b0, rb, a);
      chk("rd_addr_ack", 9'h0, {8'h0, a});
      for (int i = 0; i < n; i++) begin
         tws_master_model_inst.xfer(8'hff, i == n - 1, 1'b0, rb, a);
         chk("rd_byte", {1'b0, want[i]}, {1'b0, rb});
      end
      repeat (8) @(negedge sys_clk_in);
      chk("rd_release", 9'h0, {8'h0, sda_oe});
      chk("rd_idle", 9'h0, {8'h0, busy});
      tws_master_model_inst.stop_cond();
      wait_idle();
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk_in);
      failures++;
      $display("Error watchdog expected done seen hang");
      stop_test();
   end

   initial begin
      logic [7:0] rb;
      logic       a;
      repeat (4) @(negedge sys_clk_in);
      srst_in = 1'b0;
      repeat (12) @(negedge sys_clk_in);
      chk("rst_oe", 9'h0, {8'h0, sda_oe});
      chk("rst_idle", 9'h1, {8'h0, bus_idle});
      chk("rst_rx", 9'h0, rx_byte);
      done("reset");
      tws_master_model_inst.xfer({TYPE_SENSOR, pins, 1'b0}, 1'b1, 1'b0, rb, a);
      chk("nostart_ack", 9'h1, {8'h0, a});
      chk("nostart_rx", 9'h0, 9'(rxq.size()));
      tws_master_model_inst.stop_cond();
      wait_idle();
      done("no_start");
      for (int k = 0; k < 6; k++) begin
         pins = 3'(rnd());
         write_frame(k[0] ? TYPE_MEMORY : TYPE_SENSOR, pins, 1 + int'(rnd() % 4), -1,
                     k < 2, 1'b1);
      end
      done("write");
      write_frame(TYPE_SENSOR, pins ^ 3'h4, 2, -1, 1'b0, 1'b1);
      write_frame(4'h5, pins, 1, -1, 1'b0, 1'b1);
      done("mismatch");
      write_frame(TYPE_MEMORY, pins, 3, 1, 1'b0, 1'b1);
      done("refuse");
      write_frame(TYPE_SENSOR, pins, 2, -1, 1'b0, 1'b0);
      read_frame(TYPE_SENSOR, 3);
      read_frame(TYPE_MEMORY, 1);
      done("read");
      stop_test();
   end
endmodule
`default_nettype wire
